/* File: core/bus_event_pkg.sv */
// Constants, field layouts and carrier types for the bus data activity counter
package bus_event_pkg;

    // ------------------------------------------------------------------
    // APB register byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] SEL_A_ADDR = 12'h000;
    localparam logic [11:0] SEL_B_ADDR = 12'h004;
    localparam logic [11:0] CTRL_ADDR = 12'h008;
    localparam logic [11:0] STATUS_ADDR = 12'h00C;
    localparam logic [11:0] CNT_BASE_ADDR = 12'h010;

    // ------------------------------------------------------------------
    // Selector fields
    // ------------------------------------------------------------------
    localparam int EVSEL_HI = 31;
    localparam int EVSEL_LO = 25;
    localparam int MASK_HI = 24;
    localparam int MASK_LO = 9;
    localparam logic [31:0] SEL_WMASK = 32'hFFFF_FE00;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam logic [6:0] EV_DATA_ACTIVITY = 7'h17;
    localparam logic [6:0] EV_QUEUE_ALLOC = 7'h03;

    // Mask bit positions inside the 16-bit mask
    localparam int MB_SELF_DRIVEN = 0;
    localparam int MB_SELF_SAMPLED = 1;
    localparam int MB_NOT_SAMPLED = 2;
    localparam int MB_REQ_HI = 4;
    localparam int MB_ANY_READ = 5;
    localparam int MB_ANY_WRITE = 6;
    localparam int MB_MEM_LO = 7;
    localparam int MB_OWN_AGENT = 13;
    localparam int MB_OTHER_AGENT = 14;

    // ------------------------------------------------------------------
    // Model split, allocation sizes, resets, synchroniser
    // ------------------------------------------------------------------
    localparam logic [3:0] MODEL_SPLIT = 4'h2;
    localparam logic [7:0] LINE_BYTES = 8'h40;
    localparam logic [7:0] CHUNK_BYTES = 8'h08;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [31:0] CNT_RESET = 32'h0000_0000;
    localparam int SYNC_STAGES = 3;

    // Bus pins as seen by the processor
    typedef struct packed {
        logic ready;
        logic busy;
        logic drive;
        logic sample;
    } bus_pins_t;

    // Queue allocation report from the bus queue logic
    typedef struct packed {
        logic valid;
        logic [4:0] req_type;
        logic is_read;
        logic is_write;
        logic [2:0] mem_type;
        logic self_agent;
        logic full_line;
    } alloc_t;

endpackage

/* File: core/event_qualifier.sv */
// Per-selector event qualification for the bus data activity counter
`timescale 1ns/1ps
`default_nettype none

module event_qualifier #(
    parameter logic [3:0] MODEL = 4'h2
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [31:0] sel_i,
    input wire bus_event_pkg::bus_pins_t pins_i,
    input wire bus_event_pkg::alloc_t alloc_i,
    output logic hit_o,
    output logic [7:0] size_o
);
    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    wire logic [6:0] evsel = sel_i[bus_event_pkg::EVSEL_HI:bus_event_pkg::EVSEL_LO];
    wire logic [15:0] mask = sel_i[bus_event_pkg::MASK_HI:bus_event_pkg::MASK_LO];
    wire logic is_data = (evsel == bus_event_pkg::EV_DATA_ACTIVITY);
    wire logic is_alloc = (evsel == bus_event_pkg::EV_QUEUE_ALLOC);

    // Data-ready sub-events; each holds for as long as the bus shows it
    wire logic self_driven = pins_i.ready & pins_i.drive;
    wire logic self_sampled = pins_i.ready & pins_i.sample;
    wire logic not_sampled = pins_i.ready & ~pins_i.sample;
    wire logic data_hit = is_data & (
        (mask[bus_event_pkg::MB_SELF_DRIVEN] & self_driven) |
        (mask[bus_event_pkg::MB_SELF_SAMPLED] & self_sampled) |
        (mask[bus_event_pkg::MB_NOT_SAMPLED] & not_sampled));

    // Queue allocation terms; privilege never gates these
    wire logic req_m = (mask[bus_event_pkg::MB_REQ_HI:0] == alloc_i.req_type);
    wire logic rd_m = mask[bus_event_pkg::MB_ANY_READ] & alloc_i.is_read;
    wire logic wr_m = mask[bus_event_pkg::MB_ANY_WRITE] & alloc_i.is_write;
    wire logic any_rw = mask[bus_event_pkg::MB_ANY_READ] |
        mask[bus_event_pkg::MB_ANY_WRITE];
    wire logic mem_m = mask[bus_event_pkg::MB_MEM_LO +
        32'(alloc_i.mem_type)];
    wire logic src_m = (mask[bus_event_pkg::MB_OWN_AGENT] & alloc_i.self_agent) |
        (mask[bus_event_pkg::MB_OTHER_AGENT] & ~alloc_i.self_agent);
    wire logic new_hit = req_m & (rd_m | wr_m) & mem_m & src_m;
    wire logic old_hit = src_m & (req_m | rd_m | wr_m |
        (mem_m & ~any_rw));
    wire logic new_model = (MODEL >= bus_event_pkg::MODEL_SPLIT);
    wire logic alloc_hit = is_alloc & alloc_i.valid &
        (new_model ? new_hit : old_hit);
    wire logic [7:0] alloc_size = alloc_i.full_line ?
        bus_event_pkg::LINE_BYTES : bus_event_pkg::CHUNK_BYTES;

    // Registered so the counter sees one clean pulse per qualifying cycle
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            hit_o <= 1'b0;
            size_o <= 8'h00;
        end else if (ce_i) begin
            hit_o <= data_hit | alloc_hit;
            if (alloc_hit) begin
                size_o <= alloc_size;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_self_driven_hit: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && is_data &&
        mask[bus_event_pkg::MB_SELF_DRIVEN] && self_driven |=> hit_o)
        else $error("self driven ready not counted");
    a_no_sel_no_hit: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && !is_data && !is_alloc |=> !hit_o)
        else $error("hit without a selected event");
    a_old_model_mem: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && !new_model && is_alloc &&
        alloc_i.valid && src_m && any_rw && !req_m && !rd_m && !wr_m
        |=> !hit_o)
        else $error("memory type counted despite any read or write");
    a_alloc_size: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && alloc_hit
        |=> size_o == ($past(alloc_i.full_line) ?
            bus_event_pkg::LINE_BYTES : bus_event_pkg::CHUNK_BYTES))
        else $error("allocation size does not match the entry kind");
    c_alloc_counted: cover property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && alloc_hit);
endmodule // event_qualifier

`default_nettype wire

/* File: core/bus_activity_counter.sv */
// APB-mapped bus data activity event counters with two bus selectors
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module bus_activity_counter #(
    parameter int CNT_W = 32,
    parameter logic [3:0] MODEL = 4'h2
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Shared system bus pins, asynchronous to this clock
    input wire logic data_ready_strobe_i,
    input wire logic data_busy_strobe_i,
    input wire logic bus_drive_i,
    input wire logic bus_sample_i,
    // Queue allocation report, same clock
    input wire bus_event_pkg::alloc_t alloc_i,
    // Per-selector qualified event pulses
    output logic [1:0] event_hit_o
);
    localparam int NPIN = $bits(bus_event_pkg::bus_pins_t);

    // ------------------------------------------------------------------
    // Pin synchronisers: three flops, value moves when stage 2 and 3 agree
    // ------------------------------------------------------------------
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic [NPIN-1:0] sync3_q;
    bus_event_pkg::bus_pins_t pins_q;

    assign pin_raw = {data_ready_strobe_i, data_busy_strobe_i,
        bus_drive_i, bus_sample_i};

    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp++) begin : g_pin
            // Stage 1 feeds only stage 2, so metastability stays contained
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    sync1_q[gp] <= 1'b0;
                    sync2_q[gp] <= 1'b0;
                    sync3_q[gp] <= 1'b0;
                    pins_q[gp] <= 1'b0;
                end else if (ce_i) begin
                    sync1_q[gp] <= pin_raw[gp];
                    sync2_q[gp] <= sync1_q[gp];
                    sync3_q[gp] <= sync2_q[gp];
                    if (sync2_q[gp] == sync3_q[gp]) begin
                        pins_q[gp] <= sync3_q[gp];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] sel_q [2];
    logic [CNT_W-1:0] cnt_q [4];
    logic [3:0] cnt_en_q;
    logic [1:0] hit;
    logic [7:0] size [2];
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [1:0] event_hit_q;

    // ------------------------------------------------------------------
    // Qualifiers: only the two bus selectors carry the event
    // ------------------------------------------------------------------
    genvar gs;
    generate
        for (gs = 0; gs < 2; gs++) begin : g_sel
            event_qualifier #(
                .MODEL(MODEL)
            ) u_qual (
                .sys_clk_i(sys_clk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .sel_i(sel_q[gs]),
                .pins_i(pins_q),
                .alloc_i(alloc_i),
                .hit_o(hit[gs]),
                .size_o(size[gs])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire logic access = psel_i & penable_i;
    wire logic done = access & pready_q;
    wire logic wr_done = done & pwrite_i;
    wire logic hit_sel_a = (paddr_i == bus_event_pkg::SEL_A_ADDR);
    wire logic hit_sel_b = (paddr_i == bus_event_pkg::SEL_B_ADDR);
    wire logic hit_ctrl = (paddr_i == bus_event_pkg::CTRL_ADDR);
    wire logic hit_status = (paddr_i == bus_event_pkg::STATUS_ADDR);
    wire logic [11:0] cnt_off = paddr_i - bus_event_pkg::CNT_BASE_ADDR;
    wire logic hit_cnt = (paddr_i >= bus_event_pkg::CNT_BASE_ADDR) &&
        (cnt_off < 12'h010) && (paddr_i[1:0] == 2'b00);
    wire logic [1:0] cnt_idx = cnt_off[3:2];
    wire logic mapped = hit_sel_a | hit_sel_b | hit_ctrl | hit_status |
        hit_cnt;
    wire logic [31:0] status_word = {8'h00, size[1], size[0],
        MODEL, pins_q};
    wire logic [31:0] cnt_word = 32'(cnt_q[cnt_idx]);
    logic [31:0] rd_word;

    // Read mux as a priority chain; unmapped reads as zero
    always_comb begin
        if (hit_sel_a) begin
            rd_word = sel_q[0];
        end else if (hit_sel_b) begin
            rd_word = sel_q[1];
        end else if (hit_ctrl) begin
            rd_word = {28'h000_0000, cnt_en_q};
        end else if (hit_status) begin
            rd_word = status_word;
        end else if (hit_cnt) begin
            rd_word = cnt_word;
        end else begin
            rd_word = 32'h0000_0000;
        end
    end

    // One wait state: ready rises after the first access cycle, data latched
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_q <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~mapped;
            prdata_q <= (access & ~pready_q & ~pwrite_i) ?
                rd_word : 32'h0000_0000;
        end
    end

    // Selectors keep only event select and mask; other bits read zero
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sel_q[0] <= bus_event_pkg::SEL_RESET;
            sel_q[1] <= bus_event_pkg::SEL_RESET;
            cnt_en_q <= bus_event_pkg::CTRL_RESET;
        end else if (ce_i && wr_done) begin
            if (hit_sel_a) begin
                sel_q[0] <= pwdata_i & bus_event_pkg::SEL_WMASK;
            end else if (hit_sel_b) begin
                sel_q[1] <= pwdata_i & bus_event_pkg::SEL_WMASK;
            end else if (hit_ctrl) begin
                cnt_en_q <= pwdata_i[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Counters: 0 and 1 follow selector A, 2 and 3 follow selector B
    // ------------------------------------------------------------------
    genvar gc;
    generate
        for (gc = 0; gc < 4; gc++) begin : g_cnt
            wire logic cnt_wr = wr_done & hit_cnt & (cnt_idx == 2'(gc));
            wire logic cnt_inc = cnt_en_q[gc] & hit[gc / 2];
            // A software write wins over a same-cycle increment
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    cnt_q[gc] <= CNT_W'(bus_event_pkg::CNT_RESET);
                end else if (ce_i) begin
                    if (cnt_wr) begin
                        cnt_q[gc] <= pwdata_i[CNT_W-1:0];
                    end else if (cnt_inc) begin
                        cnt_q[gc] <= cnt_q[gc] + 1'b1;
                    end
                end
            end
        end
    endgenerate

    // Event pulses are re-registered so the outputs come from flops
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            event_hit_q <= 2'b00;
        end else if (ce_i) begin
            event_hit_q <= hit;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign event_hit_o = event_hit_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_apb_one_wait: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && psel_i && penable_i && !pready_o
        ##1 ce_i && psel_i && penable_i |-> pready_o)
        else $error("APB answer not after one wait state");
    a_cnt0_follows_a: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && cnt_en_q[0] && hit[0] &&
        !(wr_done && hit_cnt) |=> cnt_q[0] == $past(cnt_q[0]) + 1'b1)
        else $error("counter 0 missed a selector A event");
    a_cnt2_follows_b: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && cnt_en_q[2] && !hit[1] &&
        !(wr_done && hit_cnt) |=> cnt_q[2] == $past(cnt_q[2]))
        else $error("counter 2 moved without a selector B event");
    a_ready_drv_count: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && pins_q.ready && pins_q.drive &&
        sel_q[0][31:25] == bus_event_pkg::EV_DATA_ACTIVITY && sel_q[0][9]
        |=> hit[0])
        else $error("self driven ready cycle not qualified");
    a_ready_own_count: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && pins_q.ready && pins_q.sample &&
        sel_q[1][31:25] == bus_event_pkg::EV_DATA_ACTIVITY && sel_q[1][10]
        |=> hit[1])
        else $error("self sampled ready cycle not qualified");
    a_ready_other_cnt: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && pins_q.ready && !pins_q.sample &&
        sel_q[0][31:25] == bus_event_pkg::EV_DATA_ACTIVITY && sel_q[0][11]
        |=> hit[0])
        else $error("unsampled ready cycle not qualified");
    a_new_model_and: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && MODEL >= bus_event_pkg::MODEL_SPLIT &&
        sel_q[0][31:25] == bus_event_pkg::EV_QUEUE_ALLOC &&
        alloc_i.valid && sel_q[0][13:9] != alloc_i.req_type
        |=> !hit[0])
        else $error("allocation counted without request type match");
    a_old_model_src: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i && MODEL < bus_event_pkg::MODEL_SPLIT &&
        sel_q[0][31:25] == bus_event_pkg::EV_QUEUE_ALLOC && alloc_i.valid &&
        sel_q[0][13:9] == alloc_i.req_type &&
        (sel_q[0][22] && alloc_i.self_agent) |=> hit[0])
        else $error("old model allocation with match not counted");
    // Checked per pin: one pin may settle while another still toggles
    a_pin_filter: assert property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) ce_i
        |=> ((($past(sync2_q) ^ $past(sync3_q)) &
            (pins_q ^ $past(pins_q))) == '0))
        else $error("filtered pin moved while its stages disagree");
    c_data_count: cover property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) cnt_en_q[0] && hit[0] ##1 hit[0]);
    c_sel_b_count: cover property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) cnt_en_q[3] && hit[1]);
    c_apb_write: cover property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) wr_done && hit_sel_a);
    c_unmapped: cover property (@(posedge sys_clk_i)
        disable iff (sys_rst_i) pslverr_o);
endmodule // bus_activity_counter

`default_nettype wire

/* File: verif/bus_agent_model.sv */
// Far-side bus agent model that plays data transfers on the shared bus
`timescale 1ns/1ps
`default_nettype none

module bus_agent_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [1:0] kind_i,
    input wire logic [2:0] beats_i,
    output logic ready_o,
    output logic busy_o,
    output logic drive_o,
    output logic sample_o
);
    logic [2:0] left_q;

    // ------------------------------------------------------------------
    // Transfer player
    // ------------------------------------------------------------------
    // Qualifiers are inverted between transfers so a stale level never
    // looks like a valid one; only ready marks a counted beat
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left_q <= 3'h0;
            ready_o <= 1'b0;
            busy_o <= 1'b0;
            drive_o <= 1'b0;
            sample_o <= 1'b0;
        end else if (go_i) begin
            left_q <= beats_i;
            busy_o <= 1'b1;
        end else if (left_q != 3'h0) begin
            left_q <= left_q - 3'h1;
            ready_o <= 1'b1;
            busy_o <= (left_q > 3'h1);
            drive_o <= kind_i[1];
            sample_o <= kind_i[0];
        end else begin
            ready_o <= 1'b0;
            drive_o <= ~drive_o;
            sample_o <= ~sample_o;
        end
    end
endmodule // bus_agent_model

`default_nettype wire

/* File: verif/test_bus_activity_counter.sv */
// Self-checking bench for the bus data activity counter
`timescale 1ns/1ps
`default_nettype none

module test_bus_activity_counter;
    logic clk = 1'b0;
    logic rst;
    logic psel, penable, pwrite, pready, pslverr, e, go;
    logic ready, busy, drive, sample;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [31:0] prdata_old, q_old;
    logic [1:0] kind, hit;
    logic [2:0] beats;
    bus_event_pkg::alloc_t alloc;
    int n_fail = 0;
    int n_checks = 0;
    int hits;

    // ------------------------------------------------------------------
    // Clock, far-side agent and device
    // ------------------------------------------------------------------
    initial forever #2 clk = ~clk;
    bus_agent_model i_agent (.clk_i(clk), .rst_i(rst), .go_i(go),
        .kind_i(kind), .beats_i(beats), .ready_o(ready), .busy_o(busy),
        .drive_o(drive), .sample_o(sample));
    bus_activity_counter i_dut (.sys_clk_i(clk), .sys_rst_i(rst),
        .ce_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .data_ready_strobe_i(ready),
        .data_busy_strobe_i(busy), .bus_drive_i(drive),
        .bus_sample_i(sample), .alloc_i(alloc), .event_hit_o(hit));
    // Earlier-model twin on the same buses for the older trigger terms
    bus_activity_counter #(.MODEL(4'h1)) i_dut_old (.sys_clk_i(clk),
        .sys_rst_i(rst), .ce_i(1'b1), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_old), .pready_o(), .pslverr_o(),
        .data_ready_strobe_i(ready), .data_busy_strobe_i(busy),
        .bus_drive_i(drive), .bus_sample_i(sample), .alloc_i(alloc),
        .event_hit_o());

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // APB master: holds the request until pready is seen at an edge
    // An idle edge first, so psel is never set twice in one time step
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        q_old = prdata_old;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m,
            input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), exp, q & m);
    endtask

    // Plays one transfer and counts the event pulses of selector A
    task automatic xfer(input logic [1:0] k, input logic [2:0] b);
        kind <= k;
        beats <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (16) begin
            @(posedge clk);
            hits += int'(hit[0] === 1'b1);
        end
    endtask

    task automatic finish_test;
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog: whole run is a few hundred cycles
    // ------------------------------------------------------------------
    initial begin
        #200000;
        n_fail++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [1:0] kd;
        logic [2:0] b;
        logic hf;
        rst = 1'b1;
        {psel, penable, pwrite, go} = 4'h0;
        {paddr, pwdata, kind, beats} = '0;
        alloc = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(bus_event_pkg::SEL_A_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(bus_event_pkg::CTRL_ADDR, 32'hFFFF_FFFF, 32'h0000_0000);
        rd(12'h020, 32'hFFFF_FFFF, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, e});
        apb(1'b1, bus_event_pkg::CTRL_ADDR, 32'h0000_0001);
        // Every data sub-event against transfer kinds 10, 01 and 00
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, bus_event_pkg::SEL_A_ADDR, {7'h17, 16'(1 << m), 9'h0});
            for (int k = 0; k < 3; k++) begin
                kd = 2'(2 >> k);
                b = 3'(2 + 2 * ((m + k) % 2));
                hf = (m == 0) ? kd[1] : (m == 1) ? kd[0] : ~kd[0];
                apb(1'b1, bus_event_pkg::CNT_BASE_ADDR, 32'h0000_0000);
                hits = 0;
                xfer(kd, b);
                rd(bus_event_pkg::CNT_BASE_ADDR, 32'hFFFF_FFFF, hf ? b : 0);
                chk("pulses", hf ? b : 0, hits);
            end
        end
        // Two sub-events together count each cycle once
        apb(1'b1, bus_event_pkg::SEL_A_ADDR, 32'h2E00_0A00);
        apb(1'b1, bus_event_pkg::CNT_BASE_ADDR, 32'h0000_0000);
        xfer(2'b10, 3'h4);
        xfer(2'b01, 3'h2);
        xfer(2'b00, 3'h2);
        rd(bus_event_pkg::CNT_BASE_ADDR, 32'hFFFF_FFFF, 32'h0000_0006);
        // Second selector feeds counters 2 and 3; wrong code on the first
        apb(1'b1, bus_event_pkg::SEL_A_ADDR, 32'h2C00_0800);
        apb(1'b1, bus_event_pkg::SEL_B_ADDR, 32'h2E00_0800);
        apb(1'b1, bus_event_pkg::CTRL_ADDR, 32'h0000_000F);
        for (int i = 0; i < 4; i++)
            apb(1'b1, bus_event_pkg::CNT_BASE_ADDR + 12'(4 * i), 32'h0);
        xfer(2'b00, 3'h4);
        for (int i = 0; i < 4; i++)
            rd(bus_event_pkg::CNT_BASE_ADDR + 12'(4 * i), 32'hFFFF_FFFF, (i > 1) ? 4 : 0);
        // Model is read back before the allocation event is used
        rd(bus_event_pkg::STATUS_ADDR, 32'h0000_00F0, 32'h0000_0020);
        chk("old model", 32'h0000_0010, q_old & 32'h0000_00F0);
        // Queue allocation: later model needs all terms, earlier the source plus any one, memory type only with neither read nor write selected
        apb(1'b1, bus_event_pkg::SEL_A_ADDR, 32'h0650_4200);
        apb(1'b1, bus_event_pkg::CNT_BASE_ADDR, 32'h0000_0000);
        alloc <= '{1'b1, 5'h01, 1'b1, 1'b0, 3'h4, 1'b1, 1'b1};
        @(posedge clk);
        alloc <= '{1'b1, 5'h01, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0};
        @(posedge clk);
        // Memory type alone matches, but any-read is selected
        alloc <= '{1'b1, 5'h02, 1'b0, 1'b0, 3'h4, 1'b1, 1'b1};
        @(posedge clk);
        alloc <= '0;
        repeat (4) @(posedge clk);
        rd(bus_event_pkg::CNT_BASE_ADDR, 32'hFFFF_FFFF, 32'h0000_0001);
        chk("old alloc", 32'h0000_0002, q_old);
        rd(bus_event_pkg::STATUS_ADDR, 32'h0000_FFF0, 32'h0000_4020);
        finish_test();
    end
endmodule // test_bus_activity_counter

`default_nettype wire
